/* asp_consts.vh */
// Purpose: constants for the async serial fifo port
// Assumes: 125 MHz core clock, fixed 8N1 framing, no divisor latch
// Notes: register indices are the three address pins
`ifndef ASP_CONSTS_VH
`define ASP_CONSTS_VH
`define ASP_A_DATA 3'h0
`define ASP_A_IER 3'h1
`define ASP_A_FCR 3'h2
`define ASP_A_MCR 3'h4
`define ASP_A_LSR 3'h5
`define ASP_IER_RX 0
`define ASP_IER_TX 1
`define ASP_IER_LS 2
`define ASP_IER_MS 3
`define ASP_IER_PD 5
`define ASP_IER_WMASK 8'h2f
`define ASP_IER_RESET 8'h00
`define ASP_FCR_EN 0
`define ASP_FCR_RXCLR 1
`define ASP_FCR_TXCLR 2
`define ASP_FCR_DMA 3
`define ASP_MCR_PD 7
`define ASP_ISR_LS 4'h6
`define ASP_ISR_RX 4'h4
`define ASP_ISR_TO 4'hc
`define ASP_ISR_TX 4'h2
`define ASP_ISR_MS 4'h0
`define ASP_ISR_NONE 4'h1
`define ASP_LSR_RESET 8'h60
`define ASP_TRIG_0 5'h01
`define ASP_TRIG_1 5'h04
`define ASP_TRIG_2 5'h08
`define ASP_TRIG_3 5'h0e
`define ASP_FIFO_DEPTH 5'h10
`define ASP_CLK_HZ 125000000
`define ASP_BAUD 115200
`define ASP_HALF_TICK_DIV (`ASP_CLK_HZ / (32 * `ASP_BAUD))
`define ASP_START_HALVES 5'h0f
`define ASP_BIT_HALVES 5'h1f
`define ASP_TIMEOUT_HALVES 11'h500
`endif

/* asp_uart.v */
// Purpose: serial channel with holding registers, fifos and dma requests
// Assumes: host strobes and line input are synchronous to CORE_CLK_IN
// Notes: baud is a fixed divider; framing is fixed at 8N1
`include "asp_consts.vh"

module asp_fifo #(
  parameter W = 8,
  parameter DEPTH = 16,
  parameter AW = 4,
  parameter CW = 5
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire clr_in,
  input wire [CW-1:0] limit_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [W-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [W-1:0] out_data_out,
  output wire [CW-1:0] count_out
);
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [CW-1:0] count;
  reg [W-1:0] mem [0:DEPTH-1];
  wire push;
  wire pop;

  assign in_ready_out = count < limit_in;
  assign out_valid_out = count != {CW{1'b0}};
  assign out_data_out = mem[rd_ptr];
  assign count_out = count;
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_entry
      localparam [31:0] IDX_FULL = i;
      localparam [AW-1:0] IDX = IDX_FULL[AW-1:0];
      always @(posedge clk_in) begin
        if (push && wr_ptr == IDX)
          mem[i] <= in_data_in;
      end
    end
  endgenerate

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {CW{1'b0}};
    end else if (clr_in) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {CW{1'b0}};
    end else begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule

module asp_uart (
  input wire CORE_CLK_IN,
  input wire RESETN_IN,
  input wire CS_N_IN,
  input wire RD_N_IN,
  input wire WR_N_IN,
  input wire [2:0] ADDR_IN,
  input wire [7:0] DATA_IN,
  output reg [7:0] DATA_OUT,
  output reg DATA_OE_N_OUT,
  input wire SERIAL_IN,
  output reg SERIAL_OUT,
  input wire MODEM_EVENT_IN,
  output reg IRQ_OUT,
  output reg TX_DMA_REQUEST_N_OUT,
  output reg RX_DMA_REQUEST_N_OUT,
  output reg PWR_DOWN_OUT
);
  // zero on variants without power-down
  parameter [0:0] HAS_PWRDN = 1'b1;
  localparam [31:0] DIV_FULL = `ASP_HALF_TICK_DIV - 1;
  localparam [5:0] DIV_M1 = DIV_FULL[5:0];
  localparam [2:0] RX_IDLE = 3'b001;
  localparam [2:0] RX_START = 3'b010;
  localparam [2:0] RX_DATA = 3'b100;
  localparam [1:0] TX_IDLE = 2'b01;
  localparam [1:0] TX_BUSY = 2'b10;

  reg [5:0] div_cnt;
  reg tick;
  reg rd_prev;
  reg wr_prev;
  reg [7:0] irq_enable_mask;
  reg fifo_en;
  reg dma1_sel;
  reg [1:0] trig_sel;
  reg mcr_pd;
  reg [3:0] lsr_err;
  reg tx_flag;
  reg tx_cond_prev;
  reg rx_dma_hold;
  reg [10:0] to_cnt;
  reg [4:0] err_cnt;
  reg [2:0] rx_st;
  reg [4:0] rx_cnt;
  reg [3:0] rx_bit;
  reg [7:0] rx_sr;
  reg rx_prev;
  reg sk_valid;
  reg [10:0] sk_word;
  reg [1:0] tx_st;
  reg [4:0] tx_cnt;
  reg [3:0] tx_bit;
  reg [8:0] tx_sr;
  reg [4:0] trig;
  reg [3:0] isr_code;
  reg [7:0] rd_data;

  wire rd_now = !CS_N_IN && !RD_N_IN;
  wire wr_now = !CS_N_IN && !WR_N_IN;
  wire rd_act = rd_now && !rd_prev;
  wire wr_act = wr_now && !wr_prev;
  wire [4:0] q_limit = fifo_en ? `ASP_FIFO_DEPTH : 5'h01;
  wire fcr_wr = wr_act && ADDR_IN == `ASP_A_FCR;
  wire fcr_on = DATA_IN[`ASP_FCR_EN];
  wire rx_clr = fcr_wr && (fcr_on ? (DATA_IN[`ASP_FCR_RXCLR] | !fifo_en) : fifo_en);
  wire tx_clr = fcr_wr && (fcr_on ? (DATA_IN[`ASP_FCR_TXCLR] | !fifo_en) : fifo_en);
  wire dma1 = fifo_en && dma1_sel;

  wire tx_in_ready;
  wire tx_out_valid;
  wire [7:0] tx_out_data;
  wire [4:0] tx_count;
  wire tx_push = wr_act && ADDR_IN == `ASP_A_DATA;
  wire tx_pop = tx_out_valid && tx_st[0];
  wire sk_in_ready;
  wire sk_out_valid;
  wire [10:0] sk_out_data;
  wire rx_in_ready;
  wire rx_out_valid;
  wire [10:0] rx_out_data;
  wire [4:0] rx_count;
  wire rx_pop = rd_act && ADDR_IN == `ASP_A_DATA;
  wire rx_push = sk_out_valid && rx_in_ready;
  wire isr_rd = rd_act && ADDR_IN == `ASP_A_FCR;
  wire lsr_rd = rd_act && ADDR_IN == `ASP_A_LSR;

  // tx fill limit shrinks to one when fifos are off
  asp_fifo #(.W(8), .DEPTH(16), .AW(4), .CW(5)) u_txq (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RESETN_IN),
    .clr_in(tx_clr),
    .limit_in(q_limit),
    .in_valid_in(tx_push),
    .in_ready_out(tx_in_ready),
    .in_data_in(DATA_IN),
    .out_valid_out(tx_out_valid),
    .out_ready_in(tx_st[0]),
    .out_data_out(tx_out_data),
    .count_out(tx_count)
  );

  // two-entry skid so a full rx queue does not lose a finished word
  asp_fifo #(.W(11), .DEPTH(2), .AW(1), .CW(2)) u_skid (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RESETN_IN),
    .clr_in(rx_clr),
    .limit_in(2'h2),
    .in_valid_in(sk_valid),
    .in_ready_out(sk_in_ready),
    .in_data_in(sk_word),
    .out_valid_out(sk_out_valid),
    .out_ready_in(rx_in_ready),
    .out_data_out(sk_out_data),
    .count_out()
  );

  asp_fifo #(.W(11), .DEPTH(16), .AW(4), .CW(5)) u_rxq (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RESETN_IN),
    .clr_in(rx_clr),
    .limit_in(q_limit),
    .in_valid_in(sk_out_valid),
    .in_ready_out(rx_in_ready),
    .in_data_in(sk_out_data),
    .out_valid_out(rx_out_valid),
    .out_ready_in(rx_pop),
    .out_data_out(rx_out_data),
    .count_out(rx_count)
  );

  wire timeout = fifo_en && to_cnt == `ASP_TIMEOUT_HALVES;
  wire rx_avail = fifo_en ? (rx_count >= trig) : rx_out_valid;
  wire tx_cond = dma1 ? (tx_count < trig) : (tx_count == 5'h00);
  wire ls_src = irq_enable_mask[`ASP_IER_LS] && lsr_err != 4'h0;
  wire rx_src = irq_enable_mask[`ASP_IER_RX] && rx_avail;
  wire to_src = irq_enable_mask[`ASP_IER_RX] && timeout;
  wire tx_src = irq_enable_mask[`ASP_IER_TX] && tx_flag;
  wire ms_src = irq_enable_mask[`ASP_IER_MS] && MODEM_EVENT_IN;
  wire tx_idle = tx_st[0] && !tx_out_valid;
  wire [7:0] line_state = {err_cnt != 5'h00, tx_idle && tx_count == 5'h00,
                    tx_count == 5'h00, lsr_err, rx_out_valid};

  always @* begin
    case (trig_sel)
      2'b00: trig = `ASP_TRIG_0;
      2'b01: trig = `ASP_TRIG_1;
      2'b10: trig = `ASP_TRIG_2;
      default: trig = `ASP_TRIG_3;
    endcase
  end

  always @* begin
    if (ls_src)
      isr_code = `ASP_ISR_LS;
    else if (rx_src)
      isr_code = `ASP_ISR_RX;
    else if (to_src)
      isr_code = `ASP_ISR_TO;
    else if (tx_src)
      isr_code = `ASP_ISR_TX;
    else if (ms_src)
      isr_code = `ASP_ISR_MS;
    else
      isr_code = `ASP_ISR_NONE;
  end

  always @* begin
    case (ADDR_IN)
      `ASP_A_DATA: rd_data = rx_out_data[7:0];
      `ASP_A_IER: rd_data = irq_enable_mask;
      `ASP_A_FCR: rd_data = {fifo_en, fifo_en, 2'b00, isr_code};
      `ASP_A_MCR: rd_data = {mcr_pd, 7'h00};
      `ASP_A_LSR: rd_data = line_state;
      default: rd_data = 8'h00;
    endcase
  end

  // host side: registers, status and request pins
  always @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
      DATA_OUT <= 8'h00;
      DATA_OE_N_OUT <= 1'b1;
      irq_enable_mask <= `ASP_IER_RESET;
      fifo_en <= 1'b0;
      dma1_sel <= 1'b0;
      trig_sel <= 2'b00;
      mcr_pd <= 1'b0;
      lsr_err <= 4'h0;
      tx_flag <= 1'b0;
      tx_cond_prev <= 1'b0;
      rx_dma_hold <= 1'b0;
      to_cnt <= 11'h000;
      err_cnt <= 5'h00;
      IRQ_OUT <= 1'b0;
      TX_DMA_REQUEST_N_OUT <= 1'b1;
      RX_DMA_REQUEST_N_OUT <= 1'b1;
      PWR_DOWN_OUT <= 1'b0;
    end else begin
      rd_prev <= rd_now;
      wr_prev <= wr_now;
      DATA_OE_N_OUT <= !rd_now;
      if (rd_act)
        DATA_OUT <= rd_data;
      if (wr_act && ADDR_IN == `ASP_A_IER)
        irq_enable_mask <= DATA_IN & `ASP_IER_WMASK & {2'b11, HAS_PWRDN, 5'h1f};
      if (wr_act && ADDR_IN == `ASP_A_MCR)
        mcr_pd <= DATA_IN[`ASP_MCR_PD];
      if (fcr_wr) begin
        fifo_en <= fcr_on;
        if (fcr_on) begin
          dma1_sel <= DATA_IN[`ASP_FCR_DMA];
          trig_sel <= DATA_IN[7:6];
        end
      end
      // error sets win over the clearing reads
      if (sk_valid && sk_in_ready)
        lsr_err <= lsr_err | {sk_word[10:8], 1'b0};
      else if (sk_valid)
        lsr_err <= lsr_err | {sk_word[10:8], 1'b1};
      else if (lsr_rd || (isr_rd && isr_code == `ASP_ISR_LS))
        lsr_err <= 4'h0;
      tx_cond_prev <= tx_cond;
      if (tx_cond && !tx_cond_prev)
        tx_flag <= 1'b1;
      else if (tx_push || (isr_rd && isr_code == `ASP_ISR_TX))
        tx_flag <= 1'b0;
      if (rx_clr)
        err_cnt <= 5'h00;
      else if ((rx_push && sk_out_data[10:8] != 3'h0) &&
               !(rx_pop && rx_out_data[10:8] != 3'h0))
        err_cnt <= err_cnt + 5'h01;
      else if (!(rx_push && sk_out_data[10:8] != 3'h0) &&
               (rx_pop && rx_out_data[10:8] != 3'h0))
        err_cnt <= err_cnt - 5'h01;
      if (rx_count == 5'h00 || rx_push || rx_pop)
        to_cnt <= 11'h000;
      else if (tick && to_cnt != `ASP_TIMEOUT_HALVES)
        to_cnt <= to_cnt + 11'h001;
      if (rx_count >= trig || timeout)
        rx_dma_hold <= 1'b1;
      else if (rx_count == 5'h00)
        rx_dma_hold <= 1'b0;
      IRQ_OUT <= ls_src | rx_src | to_src | tx_src | ms_src;
      TX_DMA_REQUEST_N_OUT <= dma1 ? !tx_in_ready : tx_count != 5'h00;
      RX_DMA_REQUEST_N_OUT <= dma1 ? !rx_dma_hold : !rx_out_valid;
      PWR_DOWN_OUT <= irq_enable_mask[`ASP_IER_PD] && mcr_pd;
    end
  end

  // half-tick enable at 32x baud gives the 7.5 count exactly
  always @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      div_cnt <= 6'h00;
      tick <= 1'b0;
    end else begin
      tick <= div_cnt == DIV_M1;
      div_cnt <= (div_cnt == DIV_M1) ? 6'h00 : div_cnt + 6'h01;
    end
  end

  // receiver
  always @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rx_st <= RX_IDLE;
      rx_cnt <= 5'h00;
      rx_bit <= 4'h0;
      rx_sr <= 8'h00;
      rx_prev <= 1'b1;
      sk_valid <= 1'b0;
      sk_word <= 11'h000;
    end else begin
      rx_prev <= SERIAL_IN;
      sk_valid <= 1'b0;
      case (rx_st)
        RX_IDLE: begin
          rx_cnt <= 5'h00;
          if (rx_prev && !SERIAL_IN)
            rx_st <= RX_START;
        end
        RX_START: begin
          if (tick) begin
            if (rx_cnt == `ASP_START_HALVES - 5'h01) begin
              rx_cnt <= 5'h00;
              rx_bit <= 4'h0;
              rx_st <= SERIAL_IN ? RX_IDLE : RX_DATA;
            end else begin
              rx_cnt <= rx_cnt + 5'h01;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            if (rx_cnt == `ASP_BIT_HALVES) begin
              rx_cnt <= 5'h00;
              if (rx_bit == 4'h8) begin
                // tag: break, framing, parity (no parity here)
                sk_valid <= 1'b1;
                sk_word <= {!SERIAL_IN && rx_sr == 8'h00, !SERIAL_IN, 1'b0, rx_sr};
                rx_st <= RX_IDLE;
              end else begin
                rx_sr <= {SERIAL_IN, rx_sr[7:1]};
                rx_bit <= rx_bit + 4'h1;
              end
            end else begin
              rx_cnt <= rx_cnt + 5'h01;
            end
          end
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // transmitter
  always @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      tx_st <= TX_IDLE;
      tx_cnt <= 5'h00;
      tx_bit <= 4'h0;
      tx_sr <= 9'h1ff;
      SERIAL_OUT <= 1'b1;
    end else begin
      case (tx_st)
        TX_IDLE: begin
          if (tx_pop) begin
            tx_sr <= {1'b1, tx_out_data};
            tx_bit <= 4'h0;
            tx_cnt <= 5'h00;
            SERIAL_OUT <= 1'b0;
            tx_st <= TX_BUSY;
          end
        end
        TX_BUSY: begin
          if (tick) begin
            if (tx_cnt == `ASP_BIT_HALVES) begin
              tx_cnt <= 5'h00;
              if (tx_bit == 4'h9) begin
                tx_st <= TX_IDLE;
              end else begin
                SERIAL_OUT <= tx_sr[0];
                tx_sr <= {1'b1, tx_sr[8:1]};
                tx_bit <= tx_bit + 4'h1;
              end
            end else begin
              tx_cnt <= tx_cnt + 5'h01;
            end
          end
        end
        default: tx_st <= TX_IDLE;
      endcase
    end
  end
endmodule

/* asp_uart_props.sv */
// Purpose: port-level checks for the serial channel
// Assumes: HAS_PWRDN left at its default of 1
// Notes: register shadows are rebuilt from host write takes
`include "asp_consts.vh"
module asp_uart_props (
  input wire logic CORE_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic CS_N_IN,
  input wire logic RD_N_IN,
  input wire logic WR_N_IN,
  input wire logic [2:0] ADDR_IN,
  input wire logic [7:0] DATA_IN,
  input wire logic [7:0] DATA_OUT,
  input wire logic DATA_OE_N_OUT,
  input wire logic SERIAL_IN,
  input wire logic SERIAL_OUT,
  input wire logic MODEM_EVENT_IN,
  input wire logic IRQ_OUT,
  input wire logic TX_DMA_REQUEST_N_OUT,
  input wire logic RX_DMA_REQUEST_N_OUT,
  input wire logic PWR_DOWN_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_q, wr_q, en, dma, mcr7;
  logic [7:0] irq_enable_mask;
  wire rd_go = !CS_N_IN && !RD_N_IN && !rd_q;
  wire wr_go = !CS_N_IN && !WR_N_IN && !wr_q;
  // a held strobe acts once, so the shadows only follow first-cycle takes
  always @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      en <= 1'b0;
      dma <= 1'b0;
      mcr7 <= 1'b0;
      irq_enable_mask <= 8'h00;
    end else begin
      rd_q <= !CS_N_IN && !RD_N_IN;
      wr_q <= !CS_N_IN && !WR_N_IN;
      if (wr_go && ADDR_IN == `ASP_A_IER) irq_enable_mask <= DATA_IN & `ASP_IER_WMASK;
      if (wr_go && ADDR_IN == `ASP_A_FCR) en <= DATA_IN[0];
      if (wr_go && ADDR_IN == `ASP_A_FCR && DATA_IN[0]) dma <= DATA_IN[3];
      if (wr_go && ADDR_IN == `ASP_A_MCR) mcr7 <= DATA_IN[7];
    end
  end
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  property p_pwr; $stable(irq_enable_mask[5] & mcr7) |-> PWR_DOWN_OUT == (irq_enable_mask[5] & mcr7); endproperty
  a_pwr: assert property (p_pwr) else $error("power down not following enables");
  property p_mask; $stable(irq_enable_mask[3:0]) && irq_enable_mask[3:0] == 4'h0 |-> !IRQ_OUT; endproperty
  a_mask: assert property (p_mask) else $error("interrupt with all sources masked");
  property p_rst; $rose(RESETN_IN) |-> !IRQ_OUT && !PWR_DOWN_OUT; endproperty
  a_rst: assert property (p_rst) else $error("output active after reset");
  property p_ier_rd; rd_go && ADDR_IN == `ASP_A_IER |=> DATA_OUT == irq_enable_mask; endproperty
  a_ier_rd: assert property (p_ier_rd) else $error("enable mask readback wrong");
  property p_isr_en; rd_go && ADDR_IN == `ASP_A_FCR |=> DATA_OUT[7:6] == {en, en}; endproperty
  a_isr_en: assert property (p_isr_en) else $error("fifo enable bits wrong");
  property p_isr_code;
    rd_go && ADDR_IN == `ASP_A_FCR |=> DATA_OUT[5:4] == 2'b00 &&
      DATA_OUT[3:0] inside {4'h6, 4'h4, 4'hc, 4'h2, 4'h0, 4'h1};
  endproperty
  a_isr_code: assert property (p_isr_code) else $error("illegal source code");
  property p_lsr_tx; rd_go && ADDR_IN == `ASP_A_LSR ##1 DATA_OUT[6] |-> DATA_OUT[5]; endproperty
  a_lsr_tx: assert property (p_lsr_tx) else $error("shifter empty but fifo not");
  property p_lsr_err; rd_go && ADDR_IN == `ASP_A_LSR ##1 !DATA_OUT[0] |-> !DATA_OUT[7]; endproperty
  a_lsr_err: assert property (p_lsr_err) else $error("data error with empty fifo");
  property p_rx_dma0;
    rd_go && ADDR_IN == `ASP_A_LSR && (!en || !dma) |=> DATA_OUT[0] == !RX_DMA_REQUEST_N_OUT;
  endproperty
  a_rx_dma0: assert property (p_rx_dma0) else $error("rx request disagrees with ready");
endmodule
bind asp_uart asp_uart_props props_u (.CORE_CLK_IN(CORE_CLK_IN), .RESETN_IN(RESETN_IN),
  .CS_N_IN(CS_N_IN), .RD_N_IN(RD_N_IN), .WR_N_IN(WR_N_IN), .ADDR_IN(ADDR_IN),
  .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE_N_OUT(DATA_OE_N_OUT),
  .SERIAL_IN(SERIAL_IN), .SERIAL_OUT(SERIAL_OUT), .MODEM_EVENT_IN(MODEM_EVENT_IN),
  .IRQ_OUT(IRQ_OUT), .TX_DMA_REQUEST_N_OUT(TX_DMA_REQUEST_N_OUT),
  .RX_DMA_REQUEST_N_OUT(RX_DMA_REQUEST_N_OUT), .PWR_DOWN_OUT(PWR_DOWN_OUT));

/* asp_line_partner.sv */
// Purpose: serial line model facing the channel
// Assumes: 8n1 framing, bit time of 32 half-ticks of 33 clocks
// Notes: line idles high as if pulled up
module asp_line_partner #(
  parameter int BIT_CLKS = 1056
) (
  input wire logic clk_in,
  input wire logic line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_q[$];
  logic [7:0] sh;
  initial line_out = 1'b1;
  // bad stop bit only when a scenario asks for a framing fault
  task automatic send(input logic [7:0] b, input logic stop_ok);
    logic [9:0] fr;
    fr = {stop_ok, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_in);
      line_out <= fr[i];
      repeat (BIT_CLKS - 1) @(negedge clk_in);
    end
    @(negedge clk_in);
    line_out <= 1'b1;
  endtask
  task automatic glitch(input int n);
    @(negedge clk_in);
    line_out <= 1'b0;
    repeat (n) @(negedge clk_in);
    line_out <= 1'b1;
  endtask
  // samples mid-bit, lsb first
  always begin
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk_in);
      sh[i] = line_in;
    end
    got_q.push_back(sh);
    repeat (BIT_CLKS) @(posedge clk_in);
  end
endmodule

/* asp_uart_tb_top.sv */
// Purpose: self-checking bench for the serial channel
// Assumes: host strobes driven on falling clock edges
// Notes: full bit times kept, so few characters cross the line
`define CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) note_bad(m); end
module asp_uart_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, modem_ev = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] din = 8'h00;
  logic [7:0] dout, v;
  logic oe_n, ser_in, ser_out, irq, tx_req_n, rx_req_n, pwr_dn;
  int bad_count = 0, samples_checked = 0, cycles = 0;
  always #4 clk = ~clk;
  asp_uart dut_u (.CORE_CLK_IN(clk), .RESETN_IN(rst_n), .CS_N_IN(cs_n), .RD_N_IN(rd_n),
    .WR_N_IN(wr_n), .ADDR_IN(addr), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_N_OUT(oe_n),
    .SERIAL_IN(ser_in), .SERIAL_OUT(ser_out), .MODEM_EVENT_IN(modem_ev), .IRQ_OUT(irq),
    .TX_DMA_REQUEST_N_OUT(tx_req_n), .RX_DMA_REQUEST_N_OUT(rx_req_n), .PWR_DOWN_OUT(pwr_dn));
  asp_line_partner p_u (.clk_in(clk), .line_in(ser_out), .line_out(ser_in));
  task automatic note_bad(input string m);
    bad_count++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask
  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      note_bad("timeout");
      complete_run();
    end
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    {cs_n, wr_n, addr, din} <= {2'b00, a, d};
    @(negedge clk);
    {cs_n, wr_n} <= 2'b11;
    @(negedge clk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk);
    {cs_n, rd_n, addr} <= {2'b00, a};
    repeat (2) @(negedge clk);
    d = dout;
    {cs_n, rd_n} <= 2'b11;
    @(negedge clk);
  endtask
  task automatic chk_rd(input logic [2:0] a, input logic [7:0] e, input string m);
    rd(a, v);
    `CHK(v, e, m)
  endtask
  task automatic t_reset();
    chk_rd(3'h5, 8'h60, "line state reset");
    chk_rd(3'h2, 8'h01, "source reset");
    chk_rd(3'h1, 8'h00, "enable reset");
    `CHK({tx_req_n, rx_req_n, irq}, 3'b010, "dma pins reset")
  endtask
  task automatic t_irq();
    wr(3'h2, 8'hc8);
    chk_rd(3'h2, 8'h01, "fifo bits ignored");
    wr(3'h1, 8'h02);
    repeat (3) @(negedge clk);
    `CHK(irq, 1'b1, "tx empty irq")
    chk_rd(3'h2, 8'h02, "tx source code");
    repeat (3) @(negedge clk);
    `CHK(irq, 1'b0, "read clears tx source")
    modem_ev <= 1'b1;
    repeat (3) @(negedge clk);
    `CHK(irq, 1'b0, "masked modem")
    wr(3'h1, 8'h08);
    repeat (3) @(negedge clk);
    `CHK(irq, 1'b1, "modem irq")
    chk_rd(3'h2, 8'h00, "modem code");
    wr(3'h1, 8'h00);
    modem_ev <= 1'b0;
    repeat (3) @(negedge clk);
    `CHK(irq, 1'b0, "modem masked again")
    wr(3'h1, 8'hff);
    chk_rd(3'h1, 8'h2f, "unused enable bits");
    `CHK(pwr_dn, 1'b0, "power down needs modem bit")
    wr(3'h4, 8'h80);
    repeat (3) @(negedge clk);
    `CHK(pwr_dn, 1'b1, "power down on")
    wr(3'h1, 8'h00);
    wr(3'h4, 8'h00);
  endtask
  task automatic t_fifo_tx();
    wr(3'h2, 8'h49);
    chk_rd(3'h2, 8'hc1, "fifo enabled");
    `CHK(tx_req_n, 1'b0, "tx request with room")
    wr(3'h0, 8'ha5);
    for (int i = 0; i < 16; i++) wr(3'h0, 8'(i));
    `CHK(tx_req_n, 1'b1, "tx fifo full")
    chk_rd(3'h5, 8'h00, "tx busy status");
    wr(3'h2, 8'h4d);
    repeat (3) @(negedge clk);
    `CHK(tx_req_n, 1'b0, "tx room after clear")
    chk_rd(3'h5, 8'h20, "fifo empty shifter busy");
    for (int i = 0; i < 12000 && p_u.got_q.size() == 0; i++) @(negedge clk);
    `CHK(p_u.got_q.size() > 0 ? p_u.got_q[0] : 8'hxx, 8'ha5, "tx char")
    repeat (1800) @(negedge clk);
    chk_rd(3'h5, 8'h60, "transmitter idle");
  endtask
  task automatic t_rx_trig();
    wr(3'h1, 8'h01);
    for (int i = 0; i < 3; i++) p_u.send(8'h31 + 8'(i), 1'b1);
    repeat (4) @(negedge clk);
    `CHK({irq, rx_req_n}, 2'b01, "below trigger")
    chk_rd(3'h5, 8'h61, "data ready");
    p_u.send(8'h34, 1'b1);
    repeat (4) @(negedge clk);
    `CHK({irq, rx_req_n}, 2'b10, "trigger reached")
    chk_rd(3'h2, 8'hc4, "trigger source");
    chk_rd(3'h0, 8'h31, "oldest char");
    repeat (2) @(negedge clk);
    `CHK({irq, rx_req_n}, 2'b00, "dropped below trigger")
    chk_rd(3'h2, 8'hc1, "trigger source gone");
    for (int i = 0; i < 3; i++) chk_rd(3'h0, 8'h32 + 8'(i), "char order");
    repeat (2) @(negedge clk);
    `CHK(rx_req_n, 1'b1, "drained")
    chk_rd(3'h5, 8'h60, "ready cleared");
    wr(3'h1, 8'h00);
  endtask
  task automatic t_rx_err();
    wr(3'h2, 8'h01);
    wr(3'h1, 8'h04);
    p_u.send(8'h55, 1'b0);
    repeat (4) @(negedge clk);
    `CHK(rx_req_n, 1'b0, "mode 0 rx request")
    `CHK(irq, 1'b1, "line status irq")
    chk_rd(3'h5, 8'he9, "framing and data error");
    `CHK(irq, 1'b0, "status read clears line irq")
    wr(3'h1, 8'h00);
    chk_rd(3'h5, 8'he1, "error type cleared");
    chk_rd(3'h0, 8'h55, "errored char");
    chk_rd(3'h5, 8'h60, "error tag gone");
    `CHK(rx_req_n, 1'b1, "mode 0 rx empty")
    p_u.glitch(300);
    repeat (12000) @(negedge clk);
    chk_rd(3'h5, 8'h60, "false start dropped");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_irq();
    t_fifo_tx();
    t_rx_trig();
    t_rx_err();
    complete_run();
  end
endmodule
